// ### hdl/sms_shifter.sv
// SPI master/slave byte shifter with APB register access.
// Assumes SCK, MOSI and MISO pass through the pad ring as in/out/enable triples; SS is an active-low input only.
//
// Added by the designer: the address map and the APB interface to the registers.
`include "sms_params.svh"
`timescale 1ns/1ns
`default_nettype none
module sms_shifter
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire sms_pkg::sms_addr_t paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              sckIn,
    output logic                   sckOut,
    output logic                   sckOe,
    input  wire logic              mosiIn,
    output logic                   mosiOut,
    output logic                   mosiOe,
    input  wire logic              misoIn,
    output logic                   misoOut,
    output logic                   misoOe,
    input  wire logic              ssN,
    output logic                   irqReq
);
    import sms_pkg::*;

    // Pin synchronisers: index 0 sck, 1 mosi, 2 miso, 3 ss
    logic [3:0]  pinMeta_q;
    logic [3:0]  pinSync_q;
    logic        sckPrev_q;
    logic        sckPrev_d;

    logic [7:0]  ctrl_q,     ctrl_d;
    logic [3:0]  presc_q,    presc_d;
    logic [7:0]  shift_q,    shift_d;
    logic [7:0]  rxBuf_q,    rxBuf_d;
    logic        outBit_q,   outBit_d;
    logic        done_q,     done_d;
    logic        write_collision_flag_q,     write_collision_flag_d;
    logic        mode_fault_flag_q,     mode_fault_flag_d;
    logic        doneArm_q,  doneArm_d;
    logic        wcolArm_q,  wcolArm_d;
    logic        modfArm_q,  modfArm_d;
    sms_mstate_t mState_q,   mState_d;
    logic [7:0]  divCnt_q,   divCnt_d;
    logic [3:0]  halfCnt_q,  halfCnt_d;
    logic [2:0]  bitCnt_q,   bitCnt_d;
    logic        started_q,  started_d;
    logic [31:0] prdata_q,   prdata_d;
    logic        pready_q,   pready_d;
    logic        pslverr_q,  pslverr_d;
    logic        sckOut_q,   sckOut_d;
    logic        sckOe_q,    sckOe_d;
    logic        mosiOe_q,   mosiOe_d;
    logic        misoOe_q,   misoOe_d;
    logic        irq_q,      irq_d;

    logic        access;
    logic        mapped;
    logic        isMaster;
    logic        slaveCfg;
    logic        ssLow;
    logic        cpol;
    logic        cpha;
    logic        sckEdge;
    logic        leadEdge;
    logic        captureEdge;
    logic        driveEdge;
    logic        busy;
    logic        tick;
    logic        doneEvt;
    logic        din;
    logic [7:0]  halfLen;
    logic [7:0]  shiftVal;
    logic [7:0]  ctrlWr;

    // Half period of SCK in clock cycles: (prescaler+1) doubled per rate step and by the halve bit
    assign halfLen = 8'({5'h0, presc_q[2:0]} + 8'h01) << ({1'b0, ctrl_q[`SMS_CTRL_RATE_HI:`SMS_CTRL_RATE_LO]}
                     + {2'b00, presc_q[`SMS_PRESC_HALVE]});

    always_comb
    begin
        ctrl_d    = ctrl_q;
        presc_d   = presc_q;
        shift_d   = shift_q;
        rxBuf_d   = rxBuf_q;
        outBit_d  = outBit_q;
        done_d    = done_q;
        write_collision_flag_d    = write_collision_flag_q;
        mode_fault_flag_d    = mode_fault_flag_q;
        doneArm_d = doneArm_q;
        wcolArm_d = wcolArm_q;
        modfArm_d = modfArm_q;
        mState_d  = mState_q;
        divCnt_d  = divCnt_q;
        halfCnt_d = halfCnt_q;
        bitCnt_d  = bitCnt_q;
        started_d = started_q;
        ctrlWr    = pwdata[7:0];
        doneEvt   = 1'b0;
        tick      = 1'b0;

        access    = psel && penable && pready_q;
        mapped    = (paddr == `SMS_ADDR_DATA) || (paddr == `SMS_ADDR_CTRL)
                 || (paddr == `SMS_ADDR_STAT) || (paddr == `SMS_ADDR_PRESC);
        isMaster  = ctrl_q[`SMS_CTRL_MASTER_SELECT];
        slaveCfg  = !ctrl_q[`SMS_CTRL_MASTER_SELECT] && ctrl_q[`SMS_CTRL_OE];
        ssLow     = !pinSync_q[3];
        cpol      = ctrl_q[`SMS_CTRL_CPOL];
        cpha      = ctrl_q[`SMS_CTRL_CPHA];
        sckPrev_d = pinSync_q[0];

        // Master edges come from the half counter, slave edges from the synchronised pin
        if (isMaster)
        begin
            sckEdge  = 1'b0;
            leadEdge = !halfCnt_q[0];
            din      = pinSync_q[2];
        end
        else
        begin
            sckEdge  = pinSync_q[0] != sckPrev_q;
            leadEdge = sckPrev_q == cpol;
            din      = pinSync_q[1];
        end
        captureEdge = leadEdge ^ cpha;
        driveEdge   = !captureEdge;
        shiftVal    = {shift_q[6:0], din};

        if (isMaster)
            busy = mState_q == SMS_RUN;
        else if (slaveCfg)
            busy = cpha ? started_q : ssLow;
        else
            busy = 1'b0;

        // Master engine: SCK toggles only while running
        if (isMaster && mState_q == SMS_RUN)
        begin
            if (divCnt_q == halfLen - 8'h01)
            begin
                tick     = 1'b1;
                divCnt_d = 8'h00;
            end
            else
                divCnt_d = divCnt_q + 8'h01;
            if (tick)
            begin
                if (captureEdge)
                    shift_d = shiftVal;
                else
                    outBit_d = shift_q[7];
                halfCnt_d = halfCnt_q + 4'h1;
                if (halfCnt_q == `SMS_HALF_LAST)
                begin
                    mState_d = SMS_IDLE;
                    doneEvt  = 1'b1;
                    rxBuf_d  = captureEdge ? shiftVal : shift_q;
                end
            end
        end

        // Slave engine: counts capture edges while selected
        if (slaveCfg)
        begin
            if (!ssLow)
            begin
                bitCnt_d  = 3'h0;
                started_d = 1'b0;
                outBit_d  = shift_q[7];
            end
            else if (sckEdge)
            begin
                if (cpha && !started_q)
                    started_d = 1'b1;
                if (captureEdge)
                begin
                    shift_d  = shiftVal;
                    bitCnt_d = bitCnt_q + 3'h1;
                    if (bitCnt_q == `SMS_BIT_LAST)
                    begin
                        doneEvt   = 1'b1;
                        rxBuf_d   = shiftVal;
                        started_d = 1'b0;
                    end
                end
                else
                    outBit_d = shift_q[7];
            end
        end

        // Software accesses; clears are applied before the hardware sets below
        if (access)
        begin
            if (paddr == `SMS_ADDR_STAT)
            begin
                doneArm_d = done_q;
                wcolArm_d = write_collision_flag_q;
                modfArm_d = mode_fault_flag_q;
            end
            else if (paddr == `SMS_ADDR_DATA)
            begin
                if (doneArm_q)
                begin
                    done_d    = 1'b0;
                    doneArm_d = 1'b0;
                end
                if (wcolArm_q)
                begin
                    write_collision_flag_d    = 1'b0;
                    wcolArm_d = 1'b0;
                end
                if (pwrite)
                begin
                    if (busy)
                        write_collision_flag_d = 1'b1;
                    else if (!(done_q && !doneArm_q))
                    begin
                        shift_d  = pwdata[7:0];
                        outBit_d = pwdata[7];
                        if (isMaster && ctrl_q[`SMS_CTRL_OE])
                        begin
                            mState_d  = SMS_RUN;
                            divCnt_d  = 8'h00;
                            halfCnt_d = 4'h0;
                        end
                    end
                end
            end
            else if (paddr == `SMS_ADDR_CTRL && pwrite)
            begin
                if (mode_fault_flag_q && !modfArm_q)
                begin
                    ctrlWr[`SMS_CTRL_OE]   = 1'b0;
                    ctrlWr[`SMS_CTRL_MASTER_SELECT] = 1'b0;
                end
                if (modfArm_q)
                begin
                    mode_fault_flag_d    = 1'b0;
                    modfArm_d = 1'b0;
                end
                if (busy)
                begin
                    ctrlWr[`SMS_CTRL_MASTER_SELECT] = ctrl_q[`SMS_CTRL_MASTER_SELECT];
                    ctrlWr[`SMS_CTRL_CPOL] = ctrl_q[`SMS_CTRL_CPOL];
                    ctrlWr[`SMS_CTRL_CPHA] = ctrl_q[`SMS_CTRL_CPHA];
                end
                ctrl_d = ctrlWr;
            end
            else if (paddr == `SMS_ADDR_PRESC && pwrite)
                presc_d = pwdata[3:0];
        end

        if (doneEvt)
        begin
            done_d    = 1'b1;
            doneArm_d = 1'b0;
        end

        // A master seeing SS low gives up the bus at once
        if (isMaster && ssLow)
        begin
            mode_fault_flag_d                 = 1'b1;
            modfArm_d              = 1'b0;
            ctrl_d[`SMS_CTRL_OE]   = 1'b0;
            ctrl_d[`SMS_CTRL_MASTER_SELECT] = 1'b0;
            mState_d               = SMS_IDLE;
            halfCnt_d              = 4'h0;
        end

        if (mState_d == SMS_RUN)
            sckOut_d = (tick ? !sckOut_q : sckOut_q);
        else
            sckOut_d = ctrl_d[`SMS_CTRL_CPOL];
        sckOe_d  = ctrl_d[`SMS_CTRL_MASTER_SELECT] && ctrl_d[`SMS_CTRL_OE];
        mosiOe_d = ctrl_d[`SMS_CTRL_MASTER_SELECT] && ctrl_d[`SMS_CTRL_OE];
        misoOe_d = !ctrl_d[`SMS_CTRL_MASTER_SELECT] && ctrl_d[`SMS_CTRL_OE] && ssLow
                   && (!ctrl_d[`SMS_CTRL_CPHA] || started_d);
        irq_d    = done_d && ctrl_d[`SMS_CTRL_IRQ_SRC] && ctrl_d[`SMS_CTRL_IRQ_EN];

        // APB: answer is prepared in the setup cycle, one access cycle per transfer
        pready_d  = psel && !penable;
        pslverr_d = psel && !penable && !mapped;
        prdata_d  = prdata_q;
        if (psel && !penable)
        begin
            if (paddr == `SMS_ADDR_DATA)
                prdata_d = {24'h000000, rxBuf_q};
            else if (paddr == `SMS_ADDR_CTRL)
                prdata_d = {24'h000000, ctrl_q};
            else if (paddr == `SMS_ADDR_STAT)
                prdata_d = {24'h000000, done_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 4'h0};
            else if (paddr == `SMS_ADDR_PRESC)
                prdata_d = {28'h0000000, presc_q};
            else
                prdata_d = 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pinMeta_q <= 4'hf;
            pinSync_q <= 4'hf;
            sckPrev_q <= 1'b1;
            ctrl_q    <= `SMS_RESET_BYTE;
            presc_q   <= 4'h0;
            shift_q   <= `SMS_RESET_BYTE;
            rxBuf_q   <= `SMS_RESET_BYTE;
            outBit_q  <= 1'b0;
            done_q    <= 1'b0;
            write_collision_flag_q    <= 1'b0;
            mode_fault_flag_q    <= 1'b0;
            doneArm_q <= 1'b0;
            wcolArm_q <= 1'b0;
            modfArm_q <= 1'b0;
            mState_q  <= SMS_IDLE;
            divCnt_q  <= 8'h00;
            halfCnt_q <= 4'h0;
            bitCnt_q  <= 3'h0;
            started_q <= 1'b0;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            sckOut_q  <= 1'b0;
            sckOe_q   <= 1'b0;
            mosiOe_q  <= 1'b0;
            misoOe_q  <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            pinMeta_q <= {ssN, misoIn, mosiIn, sckIn};
            pinSync_q <= pinMeta_q;
            sckPrev_q <= sckPrev_d;
            ctrl_q    <= ctrl_d;
            presc_q   <= presc_d;
            shift_q   <= shift_d;
            rxBuf_q   <= rxBuf_d;
            outBit_q  <= outBit_d;
            done_q    <= done_d;
            write_collision_flag_q    <= write_collision_flag_d;
            mode_fault_flag_q    <= mode_fault_flag_d;
            doneArm_q <= doneArm_d;
            wcolArm_q <= wcolArm_d;
            modfArm_q <= modfArm_d;
            mState_q  <= mState_d;
            divCnt_q  <= divCnt_d;
            halfCnt_q <= halfCnt_d;
            bitCnt_q  <= bitCnt_d;
            started_q <= started_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            sckOut_q  <= sckOut_d;
            sckOe_q   <= sckOe_d;
            mosiOe_q  <= mosiOe_d;
            misoOe_q  <= misoOe_d;
            irq_q     <= irq_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign sckOut  = sckOut_q;
    assign sckOe   = sckOe_q;
    assign mosiOut = outBit_q;
    assign mosiOe  = mosiOe_q;
    assign misoOut = outBit_q;
    assign misoOe  = misoOe_q;
    assign irqReq  = irq_q;
endmodule // sms_shifter
`default_nettype wire

// ### hdl/sms_params.svh
// Constants of the SPI master/slave shifter: APB offsets, field positions, reset values.
// Assumes a 32-bit APB with byte addresses; registers sit in the low byte of each word.
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH
`define SMS_ADDR_DATA    8'h00
`define SMS_ADDR_CTRL    8'h04
`define SMS_ADDR_STAT    8'h08
`define SMS_ADDR_PRESC   8'h0c
`define SMS_CTRL_IRQ_EN  7
`define SMS_CTRL_OE      6
`define SMS_CTRL_IRQ_SRC 5
`define SMS_CTRL_MASTER_SELECT    4
`define SMS_CTRL_CPOL    3
`define SMS_CTRL_CPHA    2
`define SMS_CTRL_RATE_HI 1
`define SMS_CTRL_RATE_LO 0
`define SMS_STAT_DONE    7
`define SMS_STAT_WRITE_COLLISION_FLAG    6
`define SMS_STAT_MODE_FAULT_FLAG    4
`define SMS_PRESC_HALVE  3
`define SMS_RESET_BYTE   8'h00
`define SMS_HALF_LAST    4'hf
`define SMS_BIT_LAST     3'h7
`endif

// ### hdl/sms_pkg.sv
// Types shared by the shifter.
// Assumes sms_params.svh holds the numeric constants.
package sms_pkg;
    typedef logic [7:0] sms_addr_t;
    typedef enum logic {SMS_IDLE, SMS_RUN} sms_mstate_t;
endpackage

// ### dv/sms_shifter_assertions.sv
// Concurrent checks on the shifter's APB port and SPI pin triples.
// Assumes the offsets and bit positions of sms_params.svh; bound into sms_shifter.
`include "sms_params.svh"
`timescale 1ns/1ns
`default_nettype none
module sms_shifter_assertions
(
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire sms_pkg::sms_addr_t paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               sckIn,
    input wire logic               sckOut,
    input wire logic               sckOe,
    input wire logic               mosiIn,
    input wire logic               mosiOut,
    input wire logic               mosiOe,
    input wire logic               misoIn,
    input wire logic               misoOut,
    input wire logic               misoOe,
    input wire logic               ssN,
    input wire logic               irqReq
);
    import sms_pkg::*;
    logic [7:0] ctrl_q, ctrl_d;
    logic [4:0] edge_q, edge_d;
    logic       sck_q, wrAcc, gate, mapped;

    // Mirror of the control byte and count of SCK toggles since the last data or control write
    always_comb
    begin
        wrAcc = psel && penable && pready && pwrite;
        mapped = paddr inside {`SMS_ADDR_DATA, `SMS_ADDR_CTRL, `SMS_ADDR_STAT, `SMS_ADDR_PRESC};
        ctrl_d = (wrAcc && paddr == `SMS_ADDR_CTRL) ? pwdata[7:0] : ctrl_q;
        edge_d = edge_q + 5'((sckOut != sck_q) && sckOe);
        if (wrAcc && (paddr == `SMS_ADDR_DATA || paddr == `SMS_ADDR_CTRL))
            edge_d = 5'h00;
        gate = ctrl_q[`SMS_CTRL_IRQ_EN] && ctrl_q[`SMS_CTRL_IRQ_SRC];
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= 8'h00;
            edge_q <= 5'h00;
            sck_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            edge_q <= edge_d;
            sck_q <= sckOut;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence ssFall;
        $fell(ssN) && mosiOe;
    endsequence

    chk_apb_ready: assert property (apbSetup |=> pready && psel && penable)
        else $error("pready missing after setup");
    chk_apb_err: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    chk_oe_pair: assert property (sckOe == mosiOe && !(mosiOe && misoOe))
        else $error("pin enables inconsistent");
    chk_master_fault: assert property (ssFall |-> ##[1:4] !mosiOe && !sckOe)
        else $error("master kept drive with select low");
    chk_slave_release: assert property (ssN [*4] |-> !misoOe)
        else $error("slave drives data out while unselected");
    chk_irq_gate: assert property (irqReq |-> gate || $past(gate))
        else $error("interrupt without enable and source");
    chk_sck_count: assert property (edge_q <= 5'd16)
        else $error("more than eight clock pulses");
    chk_sck_idle: assert property (edge_q == 5'd16 |-> sckOut == ctrl_q[`SMS_CTRL_CPOL])
        else $error("clock not back at idle level");
    chk_mosi_hold: assert property (mosiOe && $changed(sckOut) && (sckOut ^ ctrl_q[3] ^ ctrl_q[2])
        |-> $stable(mosiOut))
        else $error("data out moved on capture edge");
endmodule // sms_shifter_assertions

bind sms_shifter sms_shifter_assertions chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .misoIn(misoIn), .misoOut(misoOut), .misoOe(misoOe), .ssN(ssN), .irqReq(irqReq));
`default_nettype wire

// ### dv/sms_spi_slave_model.sv
// Behavioural SPI slave standing on the far side of a master-mode shifter.
// Assumes the bench selects it per byte and sets polarity and phase before selecting.
`timescale 1ns/1ns
`default_nettype none
module sms_spi_slave_model
(
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       selN,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] txByte,
    output logic            miso,
    output logic      [7:0] rxByte
);
    logic [7:0] shiftQ;
    logic       sampled;
    wire logic  phaseClk;
    // Rises on the capture edge for all four timing modes
    assign phaseClk = sck ^ cpol ^ cpha;
    initial
    begin
        miso = 1'b1;
        rxByte = 8'h00;
    end
    always @(negedge selN)
    begin
        shiftQ = txByte;
        sampled = 1'b0;
        miso = txByte[7];
    end
    always @(posedge phaseClk)
    begin
        if (!selN)
        begin
            rxByte = {rxByte[6:0], mosi};
            sampled = 1'b1;
        end
    end
    // With phase set the first edge only presents the MSB
    always @(negedge phaseClk)
    begin
        if (!selN && sampled)
        begin
            shiftQ = shiftQ << 1;
            miso = shiftQ[7];
        end
    end
    // Released line shows the inverse of its last bit
    always @(posedge selN)
        miso = ~miso;
endmodule // sms_spi_slave_model
`default_nettype wire

// ### dv/tb_spi_master_slave_shifter.sv
// Self-checking bench: APB tasks, SPI slave partner, bit-banged external master.
// Assumes sms_params.svh offsets and the partner model in dv/.
`include "sms_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_spi_master_slave_shifter;
    import sms_pkg::*;
    localparam logic [7:0] SLV_TX = 8'h96;
    localparam logic [7:0] MST_TX = 8'h3b;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, irqReq, errB;
    sms_addr_t   paddr;
    logic [31:0] pwdata, prdata;
    logic        sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, ssN;
    logic        tbSck, tbMosi, slvSel, slvCpol, slvCpha, slvMiso;
    logic [7:0]  slvTx, slvRx, rd;
    wire logic   sckW, mosiW, misoW;
    int          errors, samples_checked;
    assign sckW = sckOe ? sckOut : tbSck;
    assign mosiW = mosiOe ? mosiOut : tbMosi;
    assign misoW = misoOe ? misoOut : slvMiso;

    sms_shifter uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe),
        .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe), .ssN(ssN), .irqReq(irqReq));
    sms_spi_slave_model partner (.sck(sckW), .mosi(mosiW), .selN(slvSel), .cpol(slvCpol), .cpha(slvCpha),
        .txByte(slvTx), .miso(slvMiso), .rxByte(slvRx));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One APB transfer; entered right after a rising edge, returns after one idle cycle
    task automatic apb(input logic wr, input sms_addr_t a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata[7:0];
        errB = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_done();
        rd = 8'h00;
        while (rd[`SMS_STAT_DONE] !== 1'b1)
            apb(1'b0, `SMS_ADDR_STAT, 8'h00);
    endtask

    // Mode m is {polarity, phase, rate select}; h is the expected SCK half period in clocks
    task automatic master_xfer(input logic [3:0] m, input logic [7:0] tx, input logic [7:0] sx, input int h);
        int n;
        slvCpol = m[3];
        slvCpha = m[2];
        slvTx = sx;
        apb(1'b1, `SMS_ADDR_CTRL, 8'hd0 | {4'h0, m});
        slvSel <= 1'b0;
        apb(1'b1, `SMS_ADDR_DATA, tx);
        while (sckW === m[3])
            @(posedge clk);
        n = 0;
        while (sckW !== m[3])
        begin
            @(posedge clk);
            n++;
        end
        check(n, h);
        wait_done();
        check(irqReq, 1'b0);
        apb(1'b0, `SMS_ADDR_DATA, 8'h00);
        check(rd, sx);
        check(slvRx, tx);
        check(sckW, m[3]);
        apb(1'b0, `SMS_ADDR_STAT, 8'h00);
        check(rd, 8'h00);
        slvSel <= 1'b1;
    endtask

    // One slave byte, polarity clear, clocked by the bench; a write after the first bit must collide
    task automatic slave_byte(input logic c, input logic [7:0] st, input logic [7:0] mt);
        apb(1'b1, `SMS_ADDR_CTRL, {5'h08, c, 2'b00});
        apb(1'b1, `SMS_ADDR_DATA, st);
        ssN <= 1'b0;
        repeat (4) @(posedge clk);
        check(misoOe, !c);
        for (int i = 7; i >= 0; i--)
        begin
            if (c)
                tbSck <= 1'b1;
            tbMosi <= mt[i];
            repeat (4) @(posedge clk);
            check(misoW, st[i]);
            tbSck <= !c;
            repeat (4) @(posedge clk);
            if (!c)
                tbSck <= 1'b0;
            if (i == 7)
                apb(1'b1, `SMS_ADDR_DATA, 8'h11);
        end
        repeat (4) @(posedge clk);
        ssN <= 1'b1;
        wait_done();
        check(rd, 8'hc0);
        apb(1'b0, `SMS_ADDR_DATA, 8'h00);
        check(rd, mt);
    endtask

    initial
    begin
        repeat (10000) @(posedge clk);
        errors++;
        end_of_test();
    end

    initial
    begin
        errors = 0;
        samples_checked = 0;
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {tbSck, tbMosi, slvCpol, slvCpha, slvTx} = '0;
        {ssN, slvSel} = 2'b11;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 5; a++)
        begin
            apb(1'b0, 8'(a * 4), 8'h00);
            check({23'h0, errB, rd}, {23'h0, a == 4, 8'h00});
        end
        apb(1'b1, `SMS_ADDR_PRESC, 8'h03);
        for (int m = 0; m < 4; m++)
            master_xfer(4'(m << 2), 8'h3c + 8'(m), 8'ha5 ^ 8'(m), 4);
        // Slowest rate with the halve bit: half period (3+1) << (3+1)
        apb(1'b1, `SMS_ADDR_PRESC, 8'h0b);
        master_xfer(4'hb, 8'h69, 8'hd2, 64);
        // Collision mid-transfer, then a write while done is unacknowledged
        slvCpol = 1'b0;
        slvCpha = 1'b0;
        slvTx = 8'h5a;
        apb(1'b1, `SMS_ADDR_CTRL, 8'hf0);
        slvSel <= 1'b0;
        apb(1'b1, `SMS_ADDR_DATA, 8'hc3);
        repeat (20) @(posedge clk);
        apb(1'b1, `SMS_ADDR_DATA, 8'h18);
        while (irqReq !== 1'b1)
            @(posedge clk);
        apb(1'b1, `SMS_ADDR_DATA, 8'h81);
        repeat (10) @(posedge clk);
        check(sckW, 1'b0);
        apb(1'b0, `SMS_ADDR_STAT, 8'h00);
        check(rd, 8'hc0);
        apb(1'b0, `SMS_ADDR_DATA, 8'h00);
        check(rd, 8'h5a);
        check(slvRx, 8'hc3);
        apb(1'b0, `SMS_ADDR_STAT, 8'h00);
        check({irqReq, rd}, 9'h000);
        slvSel <= 1'b1;
        // Mode fault from a low select on the master
        ssN <= 1'b0;
        repeat (6) @(posedge clk);
        ssN <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, `SMS_ADDR_STAT, 8'h00);
        check(rd, 8'h10);
        apb(1'b0, `SMS_ADDR_CTRL, 8'h00);
        check(rd, 8'ha0);
        apb(1'b1, `SMS_ADDR_CTRL, 8'h40);
        apb(1'b0, `SMS_ADDR_STAT, 8'h00);
        check(rd, 8'h00);
        // Slave bytes clocked by the bench in both phases
        slave_byte(1'b0, SLV_TX, MST_TX);
        slave_byte(1'b1, ~SLV_TX, ~MST_TX);
        end_of_test();
    end
endmodule // tb_spi_master_slave_shifter
`default_nettype wire
